// >>> design/serial_port_consts.svh
// Notes on behaviour
// - In 9-bit frames a ninth bit of 1 marks an address, 0 data.
// - Filter on in 9-bit mode: receive completes only with ninth bit 1.
// - Control bit 7 picks 8-bit (0) or 9-bit (1) frames.
// - Control bit 6 always reads 1; writes to it do nothing.
// - 8-bit mode, bit 5 set: completion needs a stop bit of 1.
// - 9-bit mode, bit 5 set: completion and interrupt need ninth bit 1.
// - Control bit 4 gates reception; 0 disables the receiver.
// - 9-bit mode sends control bit 3 as the ninth bit.
// - Accepted frame copies stop bit (8-bit) or ninth bit into bit 2.
// - Bit 1 sets at stop bit start after a byte; software clears it.
// - Bit 0 sets at stop sampling of an accepted byte; software clears.
// - With interrupts enabled, either completion flag requests an interrupt.
// - Writing the data buffer queues the byte if a slot is free; sending starts once the transmitter is idle.
// - Reading the data buffer returns the receive latch only.
// - 8-bit frame: start, eight data bits LSB first, stop; ten bits.
// - 9-bit frame: start, eight data bits, ninth bit, stop; eleven bits.
// - A frame loads latch and ninth bit only while bit 0 is clear.
// - Bit time is two baud ticks; receive timing restarts at start edge.
`ifndef SERIAL_PORT_CONSTS_SVH
`define SERIAL_PORT_CONSTS_SVH

`define SERIAL_CONTROL_ADDR 8'h98
`define SERIAL_DATA_BUFFER_ADDR 8'h99
`define SERIAL_CONTROL_RESET 8'h40
`define SERIAL_DATA_BUFFER_RESET 8'h00

`define CTRL_FRAME_FORMAT_SELECT 7
`define CTRL_UNUSED_ONE 6
`define CTRL_ADDRESS_FILTER_ENABLE 5
`define CTRL_RECEIVE_GATE 4
`define CTRL_NINTH_TX_BIT 3
`define CTRL_NINTH_RX_BIT 2
`define CTRL_TX_DONE_FLAG 1
`define CTRL_RX_DONE_FLAG 0

`define LAST_DATA_BIT 3'h7
`define BUFFER_FULL_COUNT 2'h2

`endif

// >>> design/serial_port_pkg.sv
`default_nettype none

package serial_port_pkg;

  typedef enum logic [2:0] {
    TX_IDLE = 3'h0,
    TX_START = 3'h1,
    TX_DATA = 3'h3,
    TX_NINTH = 3'h2,
    TX_STOP = 3'h6
  } tx_state_type;

  typedef enum logic [2:0] {
    RX_IDLE = 3'h0,
    RX_START = 3'h1,
    RX_DATA = 3'h3,
    RX_NINTH = 3'h2,
    RX_STOP = 3'h6
  } rx_state_type;

  typedef struct packed {
    logic [7:0] slot0;
    logic [7:0] slot1;
    logic [1:0] count;
  } buffer_state_type;

  typedef struct packed {
    logic rx_s1;
    logic rx_s2;
    logic rx_s3;
    logic rx_level;
    logic prev_level;
    logic frame_format_select;
    logic address_filter_enable;
    logic receive_gate;
    logic ninth_tx_bit;
    logic ninth_rx_bit;
    logic tx_done_flag;
    logic rx_done_flag;
    logic [7:0] rx_latch;
    logic [7:0] rdata;
    tx_state_type tx_state;
    logic [7:0] tx_shift;
    logic [2:0] tx_cnt;
    logic tx_half;
    logic tx_line;
    rx_state_type rx_state;
    logic [7:0] rx_shift;
    logic [2:0] rx_cnt;
    logic rx_phase;
    logic rx_ninth;
  } port_state_type;

endpackage

`default_nettype wire

// >>> design/two_entry_buffer.sv
`timescale 1ns/1ps
`default_nettype none
`include "serial_port_consts.svh"

module two_entry_buffer (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Filling side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [7:0] in_data,
  // Draining side
  output logic out_valid,
  input wire logic out_ready,
  output logic [7:0] out_data
);

  serial_port_pkg::buffer_state_type s;
  serial_port_pkg::buffer_state_type next_s;
  logic push;
  logic pop;

  assign in_ready = (s.count != `BUFFER_FULL_COUNT);
  assign out_valid = (s.count != 2'h0);
  assign out_data = s.slot0;
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  always_comb begin
    next_s = s;
    if (push && pop) begin
      if (s.count == 2'h1) begin
        next_s.slot0 = in_data;
      end else begin
        next_s.slot0 = s.slot1;
        next_s.slot1 = in_data;
      end
    end else if (pop) begin
      next_s.slot0 = s.slot1;
      next_s.count = s.count - 2'h1;
    end else if (push) begin
      if (s.count == 2'h0) begin
        next_s.slot0 = in_data;
      end else begin
        next_s.slot1 = in_data;
      end
      next_s.count = s.count + 2'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

endmodule
`default_nettype wire

// >>> design/serial_port_zero.sv
`timescale 1ns/1ps
`default_nettype none
`include "serial_port_consts.svh"

module serial_port_zero (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Special function register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic tx_buffer_ready,
  // Baud timer overflow
  input wire logic baud_tick,
  // Serial line
  input wire logic serial_rx_line,
  output logic serial_tx_line,
  // Interrupt
  input wire logic serial_int_enable,
  output logic serial_irq
);

  serial_port_pkg::port_state_type s;
  serial_port_pkg::port_state_type next_s;
  logic ctrl_wr;
  logic data_wr;
  logic tx_pop;
  logic tx_avail;
  logic [7:0] tx_word;
  logic tx_advance;
  logic rx_sample;
  logic rx_start_edge;
  logic rx_accept;
  logic rx_captured_bit;
  logic set_ti;
  logic [7:0] ctrl_view;

  assign ctrl_wr = reg_wr && (reg_addr == `SERIAL_CONTROL_ADDR);
  assign data_wr = reg_wr && (reg_addr == `SERIAL_DATA_BUFFER_ADDR);

  // Two more bytes may be queued while one is on the line, so writes
  // during transmission are not lost; a fourth write is refused.
  two_entry_buffer tx_buffer (
    .clk(clk),
    .rst_n(rst_n),
    .in_valid(data_wr),
    .in_ready(tx_buffer_ready),
    .in_data(reg_wdata),
    .out_valid(tx_avail),
    .out_ready(tx_pop),
    .out_data(tx_word)
  );

  assign tx_pop = (s.tx_state == serial_port_pkg::TX_IDLE);
  assign tx_advance = baud_tick && s.tx_half;
  // The receive phase restarts at the start edge, so the first sample
  // falls one tick, half a bit, into the start bit.
  assign rx_sample = baud_tick && !s.rx_phase;
  assign rx_start_edge = s.receive_gate && s.prev_level && !s.rx_level;
  assign rx_captured_bit = s.frame_format_select ? s.rx_ninth
                                                 : s.rx_level;
  assign rx_accept = (s.rx_state == serial_port_pkg::RX_STOP) && rx_sample
                     && !s.rx_done_flag
                     && (!s.address_filter_enable
                         || rx_captured_bit);
  assign set_ti = tx_advance && (((s.tx_state == serial_port_pkg::TX_DATA)
                  && (s.tx_cnt == `LAST_DATA_BIT) && !s.frame_format_select)
                  || (s.tx_state == serial_port_pkg::TX_NINTH));

  assign ctrl_view = {s.frame_format_select, 1'h1,
                      s.address_filter_enable, s.receive_gate,
                      s.ninth_tx_bit, s.ninth_rx_bit,
                      s.tx_done_flag, s.rx_done_flag};

  assign reg_rdata = s.rdata;
  assign serial_tx_line = s.tx_line;
  assign serial_irq = serial_int_enable
                      && (s.tx_done_flag || s.rx_done_flag);

  always_comb begin
    next_s = s;
    // Three-stage pin synchroniser; a level counts once the last two stages agree.
    next_s.rx_s1 = serial_rx_line;
    next_s.rx_s2 = s.rx_s1;
    next_s.rx_s3 = s.rx_s2;
    if (s.rx_s2 == s.rx_s3) begin
      next_s.rx_level = s.rx_s3;
    end
    next_s.prev_level = s.rx_level;

    // Transmitter: each bit after the start bit lasts two baud ticks.
    if (baud_tick && s.tx_state != serial_port_pkg::TX_IDLE) begin
      next_s.tx_half = !s.tx_half;
    end
    case (s.tx_state)
      serial_port_pkg::TX_IDLE: begin
        if (tx_avail) begin
          next_s.tx_shift = tx_word;
          next_s.tx_state = serial_port_pkg::TX_START;
          next_s.tx_line = 1'h0;
          next_s.tx_half = 1'h0;
        end
      end
      serial_port_pkg::TX_START: begin
        if (tx_advance) begin
          next_s.tx_state = serial_port_pkg::TX_DATA;
          next_s.tx_line = s.tx_shift[0];
          next_s.tx_cnt = 3'h0;
        end
      end
      serial_port_pkg::TX_DATA: begin
        if (tx_advance) begin
          if (s.tx_cnt == `LAST_DATA_BIT) begin
            if (s.frame_format_select) begin
              next_s.tx_state = serial_port_pkg::TX_NINTH;
              next_s.tx_line = s.ninth_tx_bit;
            end else begin
              next_s.tx_state = serial_port_pkg::TX_STOP;
              next_s.tx_line = 1'h1;
            end
          end else begin
            next_s.tx_shift = {1'h0, s.tx_shift[7:1]};
            next_s.tx_line = s.tx_shift[1];
            next_s.tx_cnt = s.tx_cnt + 3'h1;
          end
        end
      end
      serial_port_pkg::TX_NINTH: begin
        if (tx_advance) begin
          next_s.tx_state = serial_port_pkg::TX_STOP;
          next_s.tx_line = 1'h1;
        end
      end
      serial_port_pkg::TX_STOP: begin
        if (tx_advance) begin
          next_s.tx_state = serial_port_pkg::TX_IDLE;
        end
      end
      default: begin
        next_s.tx_state = serial_port_pkg::TX_IDLE;
        next_s.tx_line = 1'h1;
      end
    endcase

    // Receiver: samples at mid-bit, every second tick after the edge.
    if (baud_tick && s.rx_state != serial_port_pkg::RX_IDLE) begin
      next_s.rx_phase = !s.rx_phase;
    end
    case (s.rx_state)
      serial_port_pkg::RX_IDLE: begin
        if (rx_start_edge) begin
          next_s.rx_state = serial_port_pkg::RX_START;
          next_s.rx_phase = 1'h0;
        end
      end
      serial_port_pkg::RX_START: begin
        if (rx_sample) begin
          // A start bit that is high again at mid-bit was a glitch.
          if (s.rx_level) begin
            next_s.rx_state = serial_port_pkg::RX_IDLE;
          end else begin
            next_s.rx_state = serial_port_pkg::RX_DATA;
            next_s.rx_cnt = 3'h0;
          end
        end
      end
      serial_port_pkg::RX_DATA: begin
        if (rx_sample) begin
          next_s.rx_shift = {s.rx_level, s.rx_shift[7:1]};
          next_s.rx_cnt = s.rx_cnt + 3'h1;
          if (s.rx_cnt == `LAST_DATA_BIT) begin
            next_s.rx_state = s.frame_format_select
                              ? serial_port_pkg::RX_NINTH
                              : serial_port_pkg::RX_STOP;
          end
        end
      end
      serial_port_pkg::RX_NINTH: begin
        if (rx_sample) begin
          next_s.rx_ninth = s.rx_level;
          next_s.rx_state = serial_port_pkg::RX_STOP;
        end
      end
      serial_port_pkg::RX_STOP: begin
        if (rx_sample) begin
          next_s.rx_state = serial_port_pkg::RX_IDLE;
        end
      end
      default: begin
        next_s.rx_state = serial_port_pkg::RX_IDLE;
      end
    endcase

    // Software writes first, so a hardware set in the same cycle wins.
    if (ctrl_wr) begin
      next_s.frame_format_select =
        reg_wdata[`CTRL_FRAME_FORMAT_SELECT];
      next_s.address_filter_enable = reg_wdata[`CTRL_ADDRESS_FILTER_ENABLE];
      next_s.receive_gate = reg_wdata[`CTRL_RECEIVE_GATE];
      next_s.ninth_tx_bit = reg_wdata[`CTRL_NINTH_TX_BIT];
      next_s.ninth_rx_bit = reg_wdata[`CTRL_NINTH_RX_BIT];
      next_s.tx_done_flag = reg_wdata[`CTRL_TX_DONE_FLAG];
      next_s.rx_done_flag = reg_wdata[`CTRL_RX_DONE_FLAG];
    end
    if (set_ti) begin
      next_s.tx_done_flag = 1'h1;
    end
    if (rx_accept) begin
      next_s.rx_done_flag = 1'h1;
      next_s.rx_latch = s.rx_shift;
      next_s.ninth_rx_bit = rx_captured_bit;
    end

    if (reg_rd) begin
      if (reg_addr == `SERIAL_CONTROL_ADDR) begin
        next_s.rdata = ctrl_view;
      end else if (reg_addr == `SERIAL_DATA_BUFFER_ADDR) begin
        next_s.rdata = s.rx_latch;
      end else begin
        next_s.rdata = 8'h00;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s <= '0;
      s.rx_s1 <= 1'h1;
      s.rx_s2 <= 1'h1;
      s.rx_s3 <= 1'h1;
      s.rx_level <= 1'h1;
      s.prev_level <= 1'h1;
      s.tx_line <= 1'h1;
      s.rx_latch <= `SERIAL_DATA_BUFFER_RESET;
    end else begin
      s <= next_s;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  sequence ctrl_read_s;
    reg_rd && (reg_addr == `SERIAL_CONTROL_ADDR);
  endsequence

  sequence data_read_s;
    reg_rd && (reg_addr == `SERIAL_DATA_BUFFER_ADDR);
  endsequence

  sequence stop_sample_s;
    (s.rx_state == serial_port_pkg::RX_STOP) && rx_sample && !ctrl_wr;
  endsequence

  sequence tx_enter_s(serial_port_pkg::tx_state_type st);
    (s.tx_state == st) && ($past(s.tx_state) != st);
  endsequence

  sequence last_data_s;
    (s.rx_state == serial_port_pkg::RX_DATA) && rx_sample
    && (s.rx_cnt == `LAST_DATA_BIT);
  endsequence

  AST_CTRL_BIT6_ONE: assert property (
    ctrl_read_s |=> reg_rdata[`CTRL_UNUSED_ONE])
    else $error("control bit 6 did not read as one");

  AST_DATA_READ_LATCH: assert property (
    data_read_s |=> reg_rdata == $past(s.rx_latch))
    else $error("data read did not return the receive latch");

  AST_TI_AT_STOP: assert property (
    tx_enter_s(serial_port_pkg::TX_STOP) |-> s.tx_done_flag && s.tx_line)
    else $error("transmit flag not set at stop bit start");

  AST_TX_NINTH_BIT: assert property (
    tx_enter_s(serial_port_pkg::TX_NINTH)
    |-> s.tx_line == $past(s.ninth_tx_bit))
    else $error("ninth transmitted bit differs from control bit 3");

  AST_RX_FILTER: assert property (
    stop_sample_s ##0 (s.frame_format_select && s.address_filter_enable
    && !s.rx_ninth && !s.rx_done_flag) |=> !s.rx_done_flag)
    else $error("receive flag set for a filtered frame");

  AST_RX_FILTER_STOP: assert property (
    stop_sample_s ##0 (!s.frame_format_select && s.address_filter_enable
    && !s.rx_level && !s.rx_done_flag) |=> !s.rx_done_flag)
    else $error("receive flag set despite a low stop bit");

  AST_RX_ACCEPT: assert property (
    stop_sample_s ##0 (!s.address_filter_enable && !s.rx_done_flag)
    |=> s.rx_done_flag && s.rx_latch == $past(s.rx_shift))
    else $error("accepted frame not latched");

  AST_RX_OVERRUN_KEEP: assert property (
    stop_sample_s ##0 s.rx_done_flag |=> $stable(s.rx_latch))
    else $error("receive latch overwritten while flag set");

  AST_RX_GATED: assert property (
    (!s.receive_gate && s.rx_state == serial_port_pkg::RX_IDLE)
    |=> s.rx_state == serial_port_pkg::RX_IDLE)
    else $error("receiver left idle while gated off");

  AST_TX_IMMEDIATE: assert property (
    (tx_avail && s.tx_state == serial_port_pkg::TX_IDLE)
    |=> (s.tx_state == serial_port_pkg::TX_START) && !serial_tx_line)
    else $error("queued byte did not start at once");

  AST_IRQ_FOLLOWS: assert property (
    ((rx_accept || set_ti) && serial_int_enable) ##1 serial_int_enable
    |-> serial_irq)
    else $error("completion flag gave no interrupt request");

  AST_RX_NINTH_CAPTURE: assert property (
    rx_accept |=> s.ninth_rx_bit == ($past(s.frame_format_select)
    ? $past(s.rx_ninth) : $past(s.rx_level)))
    else $error("bit 2 did not capture the right frame bit");

  AST_RX_NINTH_SLOT: assert property (
    last_data_s ##0 s.frame_format_select
    |=> s.rx_state == serial_port_pkg::RX_NINTH)
    else $error("nine-bit frame skipped its ninth bit");

  AST_RX_STOP_SLOT: assert property (
    last_data_s ##0 !s.frame_format_select
    |=> s.rx_state == serial_port_pkg::RX_STOP)
    else $error("eight-bit frame did not go to its stop bit");

  // A bit may only change at a boundary tick, so each bit after the start bit spans two ticks.
  AST_TX_BIT_HOLD: assert property (
    (s.tx_state != serial_port_pkg::TX_IDLE && !tx_advance)
    |=> $stable(serial_tx_line))
    else $error("transmitted bit changed between bit boundaries");

  AST_TX_DONE_HOLD: assert property (
    (s.tx_done_flag && !ctrl_wr) |=> s.tx_done_flag)
    else $error("transmit flag cleared without a write");

  AST_RX_DONE_HOLD: assert property (
    (s.rx_done_flag && !ctrl_wr) |=> s.rx_done_flag)
    else $error("receive flag cleared without a write");

endmodule
`default_nettype wire

// >>> bench/serial_peer.sv
`timescale 1ns/1ps
`default_nettype none

module serial_peer #(
  parameter int HALF = 4
) (
  // Clock and baud timing
  input wire logic clk,
  input wire logic baud_tick,
  // Frame format, high for 9-bit frames
  input wire logic nine,
  // Serial lines
  input wire logic line_in,
  output logic line_out
);
  logic [8:0] got_q[$];
  logic [8:0] got;

  initial begin
    line_out = 1'b1;
  end

  task automatic tick_wait(input int n);
    repeat (n) @(posedge clk iff baud_tick);
  endtask

  task automatic send(input logic [7:0] d, input logic b8, input logic stop);
    logic [10:0] bits;
    int n;
    bits = {stop, b8, d, 1'b0};
    n = nine ? 11 : 10;
    if (!nine) begin
      bits[9] = stop;
    end
    tick_wait(1);
    for (int i = 0; i < n; i++) begin
      @(negedge clk);
      line_out = bits[i];
      tick_wait(2);
    end
    @(negedge clk);
    line_out = 1'b1;
  endtask

  // Sampling half a tick past the second tick of each slot lands inside the
  // bit whether the first start bit lasted one tick or two.
  always begin
    @(negedge line_in);
    for (int i = 0; i < 9; i++) begin
      tick_wait(2);
      repeat (HALF) @(posedge clk);
      got[i] = line_in;
    end
    got_q.push_back(got);
  end
endmodule

`default_nettype wire

// >>> bench/serial_port_zero_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "serial_port_consts.svh"

`define CHK(n, e, g) begin \
  n_checks++; \
  if ((g) !== (e)) begin \
    num_errors++; \
    $display("[FAIL] %s expected %h seen %h", n, e, g); \
  end \
end

module serial_port_zero_tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata;
  logic tx_buffer_ready;
  logic baud_tick = 1'b0;
  logic rx_line;
  logic tx_line;
  logic int_en = 1'b0;
  logic irq;
  logic nine = 1'b0;
  int num_errors = 0;
  int n_checks = 0;
  int tick_cnt = 0;
  int k;
  logic [7:0] rd, c, d, own_addr;
  logic [7:0] latch = 8'h00;
  logic b8, t9, acc;
  logic [8:0] expv, gotv;
  logic [8:0] exp_q[$];

  always #2.5 clk = ~clk;

  // The baud timer lives outside the block: one tick every eight cycles.
  always @(negedge clk) begin
    tick_cnt <= (tick_cnt + 1) % 8;
    baud_tick <= (tick_cnt == 7);
  end

  serial_port_zero dut_u (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .tx_buffer_ready(tx_buffer_ready),
    .baud_tick(baud_tick), .serial_rx_line(rx_line),
    .serial_tx_line(tx_line), .serial_int_enable(int_en),
    .serial_irq(irq));

  serial_peer #(.HALF(4)) peer_u (.clk(clk), .baud_tick(baud_tick),
    .nine(nine), .line_in(tx_line), .line_out(rx_line));

  task automatic report_and_stop();
    $display("Checks %0d, errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = v;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask

  task automatic rdr(input logic [7:0] a);
    @(negedge clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    rd = reg_rdata;
  endtask

  function automatic logic rx_accepts(input logic [7:0] ctl,
    input logic bit9);
    return ctl[4] & ~ctl[0] & (~ctl[5] | bit9);
  endfunction

  function automatic logic [7:0] ctrl_after(input logic [7:0] ctl,
    input logic bit9, input logic ok);
    return {ctl[7], 1'b1, ctl[5:3], ok ? bit9 : ctl[2], ctl[1], ctl[0] | ok};
  endfunction

  task automatic wait_frame();
    for (int w = 0; w < 600 && peer_u.got_q.size() == 0; w++) begin
      @(negedge clk);
    end
    if (peer_u.got_q.size() == 0) begin
      num_errors++;
      report_and_stop();
    end
  endtask

  initial begin
    void'($urandom(26961));
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    `CHK("tx idle", 1'b1, tx_line)
    rdr(`SERIAL_CONTROL_ADDR);
    `CHK("ctrl reset", `SERIAL_CONTROL_RESET, rd)
    rdr(`SERIAL_DATA_BUFFER_ADDR);
    `CHK("data reset", `SERIAL_DATA_BUFFER_RESET, rd)
    rdr(8'h55);
    `CHK("unmapped", 8'h00, rd)
    for (int i = 0; i < 6; i++) begin
      c = 8'($urandom);
      int_en = 1'($urandom);
      wr(`SERIAL_CONTROL_ADDR, c);
      rdr(`SERIAL_CONTROL_ADDR);
      `CHK("ctrl rw", c | 8'h40, rd)
      `CHK("irq", int_en & (c[1] | c[0]), irq)
    end
    // Fill the transmit path until it refuses; one extra write is dropped.
    for (int i = 0; i < 4; i++) begin
      nine = 1'(i);
      t9 = 1'($urandom);
      wr(`SERIAL_CONTROL_ADDR, {nine, 3'h0, t9, 3'h0});
      k = 0;
      while (tx_buffer_ready === 1'b1 && k < 6) begin
        d = 8'($urandom);
        wr(`SERIAL_DATA_BUFFER_ADDR, d);
        exp_q.push_back({nine ? t9 : 1'b1, d});
        k++;
      end
      `CHK("tx refuse", 1'b0, tx_buffer_ready)
      `CHK("tx queued", 3, k)
      wr(`SERIAL_DATA_BUFFER_ADDR, 8'hA5);
      for (int j = 0; j < k; j++) begin
        wait_frame();
        expv = exp_q.pop_front();
        gotv = peer_u.got_q.pop_front();
        `CHK("tx frame", expv, gotv)
      end
      repeat (400) @(negedge clk);
      `CHK("tx dropped", 0, peer_u.got_q.size())
      rdr(`SERIAL_CONTROL_ADDR);
      `CHK("tx done", 1'b1, rd[1])
      rdr(`SERIAL_DATA_BUFFER_ADDR);
      `CHK("rx latch kept", latch, rd)
    end
    // Random control settings cover filter, gate and overrun on reception.
    for (int i = 0; i < 24; i++) begin
      c = 8'($urandom);
      c[4] = (i % 7 != 3);
      nine = c[7];
      d = 8'($urandom);
      b8 = 1'($urandom);
      int_en = 1'($urandom);
      wr(`SERIAL_CONTROL_ADDR, c);
      peer_u.send(d, b8, nine | b8);
      repeat (8) @(negedge clk);
      acc = rx_accepts(c, b8);
      if (acc) begin
        latch = d;
      end
      rdr(`SERIAL_CONTROL_ADDR);
      `CHK("rx ctrl", ctrl_after(c, b8, acc), rd)
      `CHK("rx irq", int_en & (c[1] | c[0] | acc), irq)
      rdr(`SERIAL_DATA_BUFFER_ADDR);
      `CHK("rx data", latch, rd)
    end
    // Slave software takes an address byte, opens the filter on a match,
    // accepts one data byte, then closes the filter for the rest.
    nine = 1'b1;
    own_addr = 8'($urandom);
    wr(`SERIAL_CONTROL_ADDR, 8'hB0);
    peer_u.send(own_addr, 1'b1, 1'b1);
    repeat (8) @(negedge clk);
    rdr(`SERIAL_DATA_BUFFER_ADDR);
    `CHK("address byte", own_addr, rd)
    if (rd == own_addr) begin
      wr(`SERIAL_CONTROL_ADDR, 8'h90);
    end
    d = 8'($urandom);
    peer_u.send(d, 1'b0, 1'b1);
    repeat (8) @(negedge clk);
    rdr(`SERIAL_DATA_BUFFER_ADDR);
    `CHK("data after match", d, rd)
    wr(`SERIAL_CONTROL_ADDR, 8'hB0);
    peer_u.send(~d, 1'b0, 1'b1);
    repeat (8) @(negedge clk);
    rdr(`SERIAL_CONTROL_ADDR);
    `CHK("filtered ctrl", 8'hF0, rd)
    rdr(`SERIAL_DATA_BUFFER_ADDR);
    `CHK("filtered data", d, rd)
    report_and_stop();
  end
endmodule

`default_nettype wire
